// file: design/arcc_top.sv
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
// Function
// - Upper-byte read freezes lower byte in 10/12-bit
// - Read during completion may take newer low byte
// - 8-bit mode uses no byte freeze
// - Control write clears done flag; completion wins
// - Result holds conversion finished during that write
// - Interrupt asserts right after such a write
// - Control write sets channel, starts or stops
// - Conversion clock: bus clock or divided clock
module arcc_top import arcc_pkg::*; #(
  parameter int DATA_W = 12, // Converter sample width
  parameter int DIV_W  = 4   // Alternate divider width
) (
  input  wire logic              CLK_I,        // Bus clock, 250 MHz
  input  wire logic              RST_N_I,      // Asynchronous reset, low active
  input  wire logic              PSEL_I,       // APB select
  input  wire logic              PENABLE_I,    // APB access phase
  input  wire logic              PWRITE_I,     // APB direction
  input  wire logic [7:0]        PADDR_I,      // APB byte address
  input  wire logic [31:0]       PWDATA_I,     // APB write data
  output logic      [31:0]       PRDATA_O,     // APB read data
  output logic                   PREADY_O,     // APB ready
  output logic                   PSLVERR_O,    // APB error
  input  wire logic [DATA_W-1:0] ADC_DATA_I,   // Sampled analog value
  output logic      [3:0]        ADC_CHAN_O,   // Selected input channel
  output logic                   ADC_SAMPLE_O, // Pulse when a result is taken
  output logic                   ADC_BUSY_O,   // Conversion in progress
  output logic                   IRQ_O         // Level interrupt
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {
    ST_IDLE,
    ST_CONV
  } arcc_state_e;

  arcc_state_e      state;       // Conversion sequencer state
  arcc_state_e      next_state;  // Next sequencer state
  logic [7:0]       tick_cnt;    // Ticks spent in this conversion
  logic [7:0]       next_tick_cnt;
  arcc_csc_s        csc;         // conv_status_control_reg
  arcc_csc_s        next_csc;
  arcc_cfg_s        cfg;         // Resolution and clock setup
  arcc_cfg_s        next_cfg;
  logic [15:0]      result;      // conversion_result_reg
  logic [15:0]      next_result;
  logic             hold;        // Lower byte is frozen
  logic             next_hold;
  logic [7:0]       low_hold;    // Frozen lower byte
  logic [7:0]       next_low_hold;
  logic [31:0]      next_prdata; // Read data for the access phase
  logic             sample;      // Registered sample pulse
  logic             next_sample;

  arcc_conv_s       conv;        // Completion this cycle
  logic             conv_tick;   // Conversion clock enable
  logic             div_tick;    // Divided clock enable
  logic             setup;       // APB setup phase
  logic             access;      // APB access phase
  logic             wr;          // Write takes effect now
  logic             rd;          // Read completes now
  logic             mapped;      // Address hits a register
  logic             csc_wr;      // Write to control register
  logic             hi_rd;       // Upper result byte read
  logic             lo_rd;       // Lower result byte read
  logic             wide;        // 10- or 12-bit mode
  logic [IRQ_W-1:0] evt;         // Events to the status unit
  logic [IRQ_W-1:0] irq_sts;     // Sticky status
  logic [IRQ_W-1:0] irq_en;      // Enable mask
  logic             irq_evt;     // Masked event request
  logic [7:0]       low_view;    // Lower byte as the bus sees it

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Right-align the sample to the selected width
  function automatic logic [15:0] fmt(input logic [1:0] mode,
                                      input logic [DATA_W-1:0] d);
    logic [15:0] wide_d;
    wide_d = 16'(d);
    case (mode)
      MODE_8:  fmt = 16'(wide_d[11:4]);
      MODE_10: fmt = 16'(wide_d[11:2]);
      default: fmt = 16'(wide_d[11:0]);
    endcase
  endfunction

  // Known register offsets
  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFS_CSC)  || (a == OFS_CFG)  || (a == OFS_RESH) ||
          (a == OFS_RESL) || (a == OFS_ISTS) || (a == OFS_ICLR) ||
          (a == OFS_IEN);
  endfunction

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Zero wait states: every access finishes in its first access cycle
  assign PREADY_O  = 1'b1;
  assign setup     = PSEL_I && !PENABLE_I;
  assign access    = PSEL_I && PENABLE_I;
  assign mapped    = hit(PADDR_I);
  assign PSLVERR_O = access && !mapped;
  assign wr        = access && PWRITE_I && mapped;
  assign rd        = access && !PWRITE_I && mapped;
  assign csc_wr    = wr && (PADDR_I == OFS_CSC);
  assign hi_rd     = rd && (PADDR_I == OFS_RESH);
  assign lo_rd     = rd && (PADDR_I == OFS_RESL);
  assign wide      = (cfg.mode != MODE_8);

  // ----------------------------------------------------------------
  // Conversion clock source
  // ----------------------------------------------------------------

  // Divider stands for the separate slow clock; one clock domain kept
  arcc_clkdiv #(
    .W       (DIV_W)
  ) u_div (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .run_i   (cfg.clk_alt),
    .div_i   (DIV_W'(cfg.div)),
    .tick_o  (div_tick)
  );

  // Pick the tick source per configuration
  assign conv_tick = cfg.clk_alt ? div_tick : 1'b1;

  // ----------------------------------------------------------------
  // Completion detect
  // ----------------------------------------------------------------

  // Last tick of a running conversion produces the result
  always_comb begin
    conv.evt  = (state == ST_CONV) && conv_tick &&
                (tick_cnt == (CONV_TICKS - 8'h01));
    conv.data = fmt(cfg.mode, ADC_DATA_I);
  end

  // ----------------------------------------------------------------
  // Sequencer and control register
  // ----------------------------------------------------------------

  // Next state of sequencer, control register and result
  always_comb begin
    next_state    = state;
    next_tick_cnt = tick_cnt;
    next_csc      = csc;
    next_cfg      = cfg;
    next_result   = result;
    next_sample   = 1'b0;

    // Count ticks while converting
    case (state)
      ST_IDLE: begin
        next_tick_cnt = 8'h00;
      end
      ST_CONV: begin
        if (conv_tick) begin
          next_tick_cnt = tick_cnt + 8'h01;
        end
        if (conv.evt) begin
          next_result   = conv.data;
          next_sample   = 1'b1;
          next_tick_cnt = 8'h00;
          if (!csc.cont) begin
            next_state = ST_IDLE;          // Single mode stops here
          end
        end
      end
      default: begin
        next_state    = ST_IDLE;
        next_tick_cnt = 8'h00;
      end
    endcase

    // Control write: clear flag, new channel, start or stop
    if (csc_wr) begin
      next_csc.chan = PWDATA_I[3:0];
      next_csc.on   = PWDATA_I[4];
      next_csc.cont = PWDATA_I[5];
      next_csc.aien = PWDATA_I[6];
      next_csc.done = 1'b0;
      next_tick_cnt = 8'h00;
      if (PWDATA_I[4]) begin
        next_state = ST_CONV;
      end else begin
        next_state = ST_IDLE;              // Stops continuous runs
      end
    end

    // A completion in the write cycle keeps the flag set and the data
    if (conv.evt) begin
      next_csc.done = 1'b1;
    end

    // Single mode leaves the running bit clear when done
    if (conv.evt && !csc.cont && !csc_wr) begin
      next_csc.on = 1'b0;
    end

    // Configuration register; reserved bit forced to zero
    if (wr && (PADDR_I == OFS_CFG)) begin
      next_cfg      = arcc_cfg_s'(PWDATA_I[7:0]);
      next_cfg.rsvd = 1'b0;
      if (PWDATA_I[1:0] == 2'h3) begin
        next_cfg.mode = MODE_12;           // Undefined code maps to widest
      end
    end
  end

  // Registers only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state    <= ST_IDLE;
      tick_cnt <= 8'h00;
      csc      <= CSC_RST;
      cfg      <= CFG_RST;
      result   <= 16'h0000;
      sample   <= 1'b0;
    end else begin
      state    <= next_state;
      tick_cnt <= next_tick_cnt;
      csc      <= next_csc;
      cfg      <= next_cfg;
      result   <= next_result;
      sample   <= next_sample;
    end
  end

  // ----------------------------------------------------------------
  // Byte coherency
  // ----------------------------------------------------------------

  // Freeze logic keeps the low byte from the high byte's conversion.
  // The freeze takes the completing result over the register, so a completion on
  // the very edge of the upper read slips the new low byte in; this
  // reproduces the converter's known behaviour rather than fixing it.
  always_comb begin
    next_hold     = hold;
    next_low_hold = low_hold;
    if (hi_rd && wide) begin
      next_hold = 1'b1;
      if (conv.evt) begin
        next_low_hold = conv.data[7:0];
      end else begin
        next_low_hold = result[7:0];
      end
    end else if (lo_rd || !wide) begin
      next_hold = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold     <= 1'b0;
      low_hold <= 8'h00;
    end else begin
      hold     <= next_hold;
      low_hold <= next_low_hold;
    end
  end

  // Lower byte seen by the bus: frozen copy or live value
  assign low_view = (hold && wide) ? low_hold : result[7:0];

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------

  // Completion and the upper-read collision are both reported
  always_comb begin
    evt               = '0;
    evt[IRQ_DONE_BIT] = conv.evt;
    evt[IRQ_RACE_BIT] = hi_rd && wide && conv.evt;
  end

  arcc_irq #(
    .N        (IRQ_W)
  ) u_irq (
    .clk_i    (CLK_I),
    .rst_n_i  (RST_N_I),
    .evt_i    (evt),
    .clr_wr_i (wr && (PADDR_I == OFS_ICLR)),
    .en_wr_i  (wr && (PADDR_I == OFS_IEN)),
    .wdata_i  (PWDATA_I[IRQ_W-1:0]),
    .sts_o    (irq_sts),
    .en_o     (irq_en),
    .irq_o    (irq_evt)
  );

  // Flag left set by a racing write raises the line at once
  assign IRQ_O = (csc.aien && csc.done) || irq_evt;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Captured in setup so the data output comes from a flip-flop.
  // Trade-off: a value changing between setup and access is seen
  // one access late; the freeze itself acts at the access edge.
  always_comb begin
    next_prdata = PRDATA_O;
    if (setup && !PWRITE_I) begin
      case (PADDR_I)
        OFS_CSC:  next_prdata = 32'(csc);
        OFS_CFG:  next_prdata = 32'(cfg);
        OFS_RESH: next_prdata = 32'(result[15:8]);
        OFS_RESL: next_prdata = 32'(low_view);
        OFS_ISTS: next_prdata = 32'(irq_sts);
        OFS_IEN:  next_prdata = 32'(irq_en);
        default:  next_prdata = 32'h00000000; // Clear register and holes
      endcase
    end
  end

  // Registers only
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h00000000;
    end else begin
      PRDATA_O <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Converter-facing outputs
  // ----------------------------------------------------------------

  // Channel and status straight from registers
  assign ADC_CHAN_O   = csc.chan;
  assign ADC_BUSY_O   = (state == ST_CONV);
  assign ADC_SAMPLE_O = sample;

endmodule // arcc_top

// file: design/arcc_pkg.sv
package arcc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB window
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CSC  = 8'h00; // conv_status_control_reg
  localparam logic [7:0] OFS_CFG  = 8'h04; // Resolution and clock setup
  localparam logic [7:0] OFS_RESH = 8'h08; // conversion_result_reg, upper byte
  localparam logic [7:0] OFS_RESL = 8'h0C; // conversion_result_reg, lower byte
  localparam logic [7:0] OFS_ISTS = 8'h10; // Sticky event status, read only
  localparam logic [7:0] OFS_ICLR = 8'h14; // Event clear, write only
  localparam logic [7:0] OFS_IEN  = 8'h18; // Event enable

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_8  = 2'h0,
    MODE_10 = 2'h1,
    MODE_12 = 2'h2
  } arcc_mode_e;

  typedef struct packed {
    logic       done;  // conversion_done_flag, bit 7, read only
    logic       aien;  // Converter interrupt enable, bit 6
    logic       cont;  // Continuous conversion, bit 5
    logic       on;    // Converter running, bit 4
    logic [3:0] chan;  // Input channel, bits 3:0
  } arcc_csc_s;

  typedef struct packed {
    logic [3:0] div;     // Alternate clock divide, bits 7:4
    logic       rsvd;    // Bit 3, reads zero
    logic       clk_alt; // Bit 2: 1 = divided clock, 0 = bus clock
    logic [1:0] mode;    // Bits 1:0, result width
  } arcc_cfg_s;

  typedef struct packed {
    logic        evt;  // Completion pulse
    logic [15:0] data; // Right-aligned result
  } arcc_conv_s;

  localparam arcc_csc_s CSC_RST = 8'h00;
  localparam arcc_cfg_s CFG_RST = 8'h32; // Divide by 4, 12-bit, bus clock

  localparam int IRQ_DONE_BIT = 0; // Conversion complete
  localparam int IRQ_RACE_BIT = 1; // Upper-byte read hit a completion
  localparam int IRQ_W        = 2;

  // Conversion length in conversion-clock ticks
  localparam logic [7:0] CONV_TICKS = 8'h0E;

endpackage

// file: design/arcc_clkdiv.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Tick divider: one-cycle enable every (div+1) clocks
// ------------------------------------------------------------------
module arcc_clkdiv import arcc_pkg::*; #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         run_i,   // Hold counter cleared when low
  input  wire logic [W-1:0] div_i,   // Divide ratio minus one
  output logic              tick_o   // Enable pulse
);

  logic [W-1:0] cnt;       // Running count
  logic [W-1:0] next_cnt;  // Next count
  logic         next_tick; // Next pulse

  // Count up to the ratio minus one, then wrap with a pulse
  always_comb begin
    next_cnt  = '0;
    next_tick = 1'b0;
    if (run_i) begin
      if (cnt >= div_i) begin
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule // arcc_clkdiv

// file: design/arcc_irq.sv
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Sticky event status with enable mask and one level output
// ------------------------------------------------------------------
module arcc_irq import arcc_pkg::*; #(
  parameter int N = IRQ_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [N-1:0] evt_i,    // Event pulses
  input  wire logic         clr_wr_i, // Write to the clear register
  input  wire logic         en_wr_i,  // Write to the enable register
  input  wire logic [N-1:0] wdata_i,  // Bus write data
  output logic      [N-1:0] sts_o,    // Sticky status
  output logic      [N-1:0] en_o,     // Enable mask
  output logic              irq_o     // Level request
);

  logic [N-1:0] next_sts; // Next status
  logic [N-1:0] next_en;  // Next mask

  // Set beats clear so an event in the clear cycle survives
  always_comb begin
    next_sts = sts_o;
    next_en  = en_o;
    if (clr_wr_i) begin
      next_sts = sts_o & ~wdata_i;
    end
    next_sts = next_sts | evt_i;
    if (en_wr_i) begin
      next_en = wdata_i;
    end
  end

  // Registers only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sts_o <= '0;
      en_o  <= '0;
    end else begin
      sts_o <= next_sts;
      en_o  <= next_en;
    end
  end

  assign irq_o = |(sts_o & en_o);

endmodule // arcc_irq

// file: tb/arcc_sva.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port-level checker
// ----------------------------------------------------------------
module arcc_sva import arcc_pkg::*; #(
  parameter int DATA_W = 12, // Sample width
  parameter int DIV_W  = 4   // Divider width
) (
  input wire logic              CLK_I,
  input wire logic              RST_N_I,
  input wire logic              PSEL_I,
  input wire logic              PENABLE_I,
  input wire logic              PWRITE_I,
  input wire logic [7:0]        PADDR_I,
  input wire logic [31:0]       PWDATA_I,
  input wire logic [31:0]       PRDATA_O,
  input wire logic              PREADY_O,
  input wire logic              PSLVERR_O,
  input wire logic [DATA_W-1:0] ADC_DATA_I,
  input wire logic [3:0]        ADC_CHAN_O,
  input wire logic              ADC_SAMPLE_O,
  input wire logic              ADC_BUSY_O,
  input wire logic              IRQ_O
);
  logic csc_wr;  // Accepted control write
  logic bad_adr; // Outside the register map
  logic rd_set;  // Read setup cycle
  assign csc_wr  = PSEL_I && PENABLE_I && PWRITE_I && (PADDR_I == OFS_CSC);
  assign bad_adr = (PADDR_I[1:0] != 2'h0) || (PADDR_I > OFS_IEN);
  assign rd_set  = PSEL_I && !PENABLE_I && !PWRITE_I;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  AST_READY_NOWAIT: assert property (PSEL_I |-> PREADY_O)
    else $error("ready low during transfer");
  AST_ERR_MAP: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == bad_adr)
    else $error("error response does not match map");
  AST_CHAN_SET: assert property (csc_wr |=> ADC_CHAN_O == $past(PWDATA_I[3:0]))
    else $error("channel not taken from control write");
  AST_BUSY_START: assert property (csc_wr && PWDATA_I[4] |=> ADC_BUSY_O)
    else $error("converter did not start");
  AST_BUSY_STOP: assert property (csc_wr && !PWDATA_I[4] |=> !ADC_BUSY_O [*2])
    else $error("converter did not stop");
  AST_SAMPLE_PULSE: assert property (ADC_SAMPLE_O |=> !ADC_SAMPLE_O)
    else $error("sample pulse too long");
  AST_SAMPLE_BUSY: assert property (ADC_SAMPLE_O |-> $past(ADC_BUSY_O))
    else $error("sample without conversion");
  AST_RACE_IRQ: assert property (
    ADC_SAMPLE_O && $past(csc_wr) && $past(PWDATA_I[6]) |-> IRQ_O)
    else $error("interrupt missing after racing write");
  AST_RDATA_HOLD: assert property (!rd_set |=> $stable(PRDATA_O))
    else $error("read data moved outside read setup");

  // Main scenarios reached
  COV_RACE_WR: cover property (ADC_SAMPLE_O && $past(csc_wr));
  COV_SAMPLE: cover property (ADC_SAMPLE_O && IRQ_O);
  COV_ERR: cover property (PSLVERR_O);
endmodule // arcc_sva

bind arcc_top arcc_sva #(.DATA_W(DATA_W), .DIV_W(DIV_W)) arcc_sva_inst (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .ADC_DATA_I(ADC_DATA_I),
  .ADC_CHAN_O(ADC_CHAN_O), .ADC_SAMPLE_O(ADC_SAMPLE_O), .ADC_BUSY_O(ADC_BUSY_O),
  .IRQ_O(IRQ_O));

// file: tb/arcc_host_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Processor side: APB master tasks
// ----------------------------------------------------------------
module arcc_host_model (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o
);
  // Idle bus at time zero
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h00;
    pwdata_o  = 32'h0;
  end

  // One transfer; released address and data lines show inverted junk, not stale data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    psel_o   <= 1'b1;
    pwrite_o <= w;
    paddr_o  <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    q = prdata_i;
    e = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    paddr_o   <= ~a;
    pwdata_o  <= ~d;
  endtask
endmodule // arcc_host_model

// file: tb/arcc_top_tb.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------
module arcc_top_tb import arcc_pkg::*;;
  logic        clk, rst_n;          // Clock and reset
  logic [11:0] adc_data;            // Analog sample source
  logic        psel, penable, pwrite, pready, pslverr, smp, busy, irq;
  logic [7:0]  paddr;               // Bus address
  logic [31:0] pwdata, prdata, rdv; // Bus data
  logic        rerr;                // Error seen on read
  logic [3:0]  chan;                // Channel output
  int          err_count, num_checks, n, per;

  arcc_top arcc_top_inst (
    .CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .ADC_DATA_I(adc_data), .ADC_CHAN_O(chan), .ADC_SAMPLE_O(smp),
    .ADC_BUSY_O(busy), .IRQ_O(irq));
  arcc_host_model arcc_host_model_inst (
    .clk_i(clk), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    arcc_host_model_inst.xfer(1'b1, a, d, rdv, rerr);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    arcc_host_model_inst.xfer(1'b0, a, 32'h0, rdv, rerr);
    chk("read data", rdv, exp);
  endtask
  task irq_is(input logic exp);
    @(negedge clk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask
  // Count settled cycles until the sample pulse
  task wait_smp();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (smp !== 1'b1 && n < 2000);
    if (smp !== 1'b1) err_count++;   // Missing pulse is a mismatch
  endtask
  // Land the next access edge on the next completion edge
  task sync(input logic [11:0] v);
    wait_smp();
    @(posedge clk);
    adc_data <= v;
    repeat (per - 4) @(posedge clk);
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    adc_data = 12'hABC;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk(OFS_CSC, 32'h00);
    rchk(OFS_CFG, 32'h32);
    rchk(OFS_ISTS, 32'h00);
    arcc_host_model_inst.xfer(1'b0, 8'h1C, 32'h0, rdv, rerr);
    chk("unmapped error", {31'h0, rerr}, 32'h1);
    chk("unmapped data", rdv, 32'h0);
    // Single conversion, interrupt raise, mask and clear
    wr(OFS_IEN, 32'h1);
    wr(OFS_CSC, 32'h15);
    wait_smp();
    chk("conv cycles", n, 32'(CONV_TICKS) + 32'd1);
    chk("channel", {28'h0, chan}, 32'h5);
    rchk(OFS_CSC, 32'h85);
    rchk(OFS_RESH, 32'h0A);
    rchk(OFS_RESL, 32'hBC);
    irq_is(1'b1);
    wr(OFS_IEN, 32'h0);
    irq_is(1'b0);
    wr(OFS_IEN, 32'h1);
    irq_is(1'b1);
    wr(OFS_ISTS, 32'h3);
    rchk(OFS_ISTS, 32'h1);
    wr(OFS_ICLR, 32'h1);
    irq_is(1'b0);
    rchk(OFS_ISTS, 32'h0);
    wr(OFS_IEN, 32'h0);
    // 8-bit and 10-bit result layout
    adc_data <= 12'h555;
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CFG, 32'h30 | m);
      wr(OFS_CSC, 32'h10);
      wait_smp();
      rchk(OFS_RESH, m);
      rchk(OFS_RESL, 32'h55);
    end
    // Divided conversion clock, divide by two
    wr(OFS_CFG, 32'h16);
    wr(OFS_CSC, 32'h10);
    wait_smp();
    chk("alt clock cycles", n, 32'(2 * CONV_TICKS + 1));
    // Reserved bit reads zero, undefined width code maps to 12-bit
    wr(OFS_CFG, 32'h3B);
    rchk(OFS_CFG, 32'h32);
    // Continuous run: upper read freezes lower byte
    adc_data <= 12'h123;
    wr(OFS_CSC, 32'h30);
    wait_smp();
    rchk(OFS_RESH, 32'h01);
    @(posedge clk);
    adc_data <= 12'h456;
    wait_smp();
    wait_smp();
    per = n;
    rchk(OFS_RESL, 32'h23);
    // Upper read on a completion edge takes the newer lower byte
    wr(OFS_IEN, 32'h2);
    sync(12'h789);
    rchk(OFS_RESH, 32'h04);
    rchk(OFS_RESL, 32'h89);
    rchk(OFS_ISTS, 32'h3);
    irq_is(1'b1);
    wr(OFS_CSC, 32'h00);
    wr(OFS_IEN, 32'h0);
    wr(OFS_ICLR, 32'h3);
    rchk(OFS_ISTS, 32'h0);
    // Control write racing a completion keeps the flag
    wr(OFS_CSC, 32'h35);
    sync(12'h3CC);
    wr(OFS_CSC, 32'h45);
    irq_is(1'b1);
    chk("busy", {31'h0, busy}, 32'h0);
    rchk(OFS_CSC, 32'hC5);
    rchk(OFS_RESH, 32'h03);
    rchk(OFS_RESL, 32'hCC);
    wr(OFS_CSC, 32'h00);
    wr(OFS_CSC, 32'h05);
    rchk(OFS_CSC, 32'h05);
    irq_is(1'b0);
    wrap_up();
  end
endmodule // arcc_top_tb
